//--- src/sss_cfg.svh
// timing counts and bus constants for the standby control block
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH
// internal initialisation length, in reference clock input cycles
`define SSS_INIT_REFCLKS 2400
`define SSS_INIT_CNT_W 12
// seven-bit slave address of this device (plain default)
`define SSS_TWI_ADDR 7'h10
// host side power-down spacings, in microseconds, then block clock rate and the same spacings in block clock cycles
`define SSS_T_CLKOFF_US 100
`define SSS_T_SUPPLY_US 200
`define SSS_CLK_MHZ 40
`define SSS_T_CLKOFF_CYC (`SSS_T_CLKOFF_US * `SSS_CLK_MHZ)
`define SSS_T_SUPPLY_CYC (`SSS_T_SUPPLY_US * `SSS_CLK_MHZ)
`endif

//--- src/sss_pkg.sv
// types shared by the standby control block
`default_nettype none
package sss_pkg;
    typedef enum logic [1:0] {SSS_HARD, SSS_SOFT, SSS_STREAM} sss_state_e;
    typedef enum logic [2:0] {TW_IDLE, TW_ADDR, TW_ACK, TW_DATA, TW_SKIP} sss_twi_e;
endpackage : sss_pkg
`default_nettype wire

//--- src/sss_twi_if.sv
// bus condition signals passed from the two-wire front end
`timescale 1ns/1ps
`default_nettype none
interface sss_twi_if;
    logic bus_idle;
    logic start_p;
    logic stop_p;
    logic addr_hit;
    modport cond (output bus_idle, start_p, stop_p, addr_hit);
    modport user (input  bus_idle, start_p, stop_p, addr_hit);
endinterface : sss_twi_if
`default_nettype wire

//--- src/sss_twi_cond.sv
// two-wire bus front end: conditions, byte framing and acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
module sss_twi_cond
    import sss_pkg::*;
(
    input  wire logic ref_clk,   // block clock
    input  wire logic rst,       // sync reset, high
    input  wire logic scl_in,    // serial clock pin
    input  wire logic sda_in,    // serial data pin
    output var  logic sda_out,   // serial data drive level
    output var  logic sda_oe_n,  // low while driving
    sss_twi_if.cond   tw         // conditions to the core
);
    logic     scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic     scl_rise, scl_fall, start_c, stop_c;
    sss_twi_e ph_r;
    logic [2:0] bit_r;
    logic [7:0] sh_r;
    logic       ack_r;
    logic       rd_r;    // direction bit of the last address byte

    // two-stage synchronisers, then one more stage for edges
    always_ff @(posedge ref_clk) begin
        scl_s1 <= scl_in;
        scl_s2 <= scl_s1;
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        scl_d  <= scl_s2;
        sda_d  <= sda_s2;
    end

    // start: data falls with clock high; stop: data rises
    assign start_c  = scl_s2 & scl_d & sda_d & ~sda_s2;  // [RULE14]
    assign stop_c   = scl_s2 & scl_d & ~sda_d & sda_s2;  // [RULE15]
    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;

    // condition flags, registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tw.bus_idle <= 1'b0;
            tw.start_p  <= 1'b0;
            tw.stop_p   <= 1'b0;
        end else begin
            tw.bus_idle <= scl_s2 & sda_s2;  // [RULE13]
            tw.start_p  <= start_c;
            tw.stop_p   <= stop_c;
        end
    end

    // framing: start or restart, address byte, ack, message bytes, stop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ph_r        <= TW_IDLE;
            bit_r       <= 3'h0;
            sh_r        <= 8'h00;
            rd_r        <= 1'b0;
            tw.addr_hit <= 1'b0;
        end else if (start_c) begin  // [RULE14] restart allowed anywhere
            ph_r        <= TW_ADDR;
            bit_r       <= 3'h0;
            tw.addr_hit <= 1'b0;
        end else if (stop_c) begin  // [RULE15]
            ph_r        <= TW_IDLE;
            tw.addr_hit <= 1'b0;
        end else if (scl_rise && (ph_r == TW_ADDR || ph_r == TW_DATA)) begin
            sh_r  <= {sh_r[6:0], sda_s2};
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7) begin  // [RULE16]
                if (ph_r == TW_ADDR) begin
                    tw.addr_hit <= (sh_r[6:0] == `SSS_TWI_ADDR);
                    ph_r <= (sh_r[6:0] == `SSS_TWI_ADDR) ? TW_ACK : TW_SKIP;
                    rd_r <= sda_s2;  // kept apart so data bits never look like a read
                end else begin
                    ph_r <= TW_ACK;
                end
            end
        end else if (scl_fall && ph_r == TW_ACK && !ack_r) begin
            ph_r <= ph_r;
        end else if (scl_fall && ph_r == TW_ACK && ack_r) begin
            // reads get no data from here; writes keep being acknowledged
            ph_r <= rd_r ? TW_SKIP : TW_DATA;
        end
    end

    // acknowledge slot: drive data low from one clock fall to the next
    always_ff @(posedge ref_clk) begin
        if (rst || start_c || stop_c) begin
            ack_r    <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (scl_fall && ph_r == TW_ACK) begin
            ack_r    <= ~ack_r;
            sda_oe_n <= ack_r;  // [RULE16]
        end
    end

    // only the data line is ever driven, and only low
    always_ff @(posedge ref_clk) begin
        sda_out <= 1'b0;  // [RULE12]
    end

    property p_start_cond;
        @(posedge ref_clk) disable iff (rst)
        start_c |=> tw.start_p && !tw.bus_idle;
    endproperty
    a_start_cond: assert property (p_start_cond) else $error("start not flagged");  // [RULE14]

    property p_stop_idle;
        @(posedge ref_clk) disable iff (rst)
        stop_c |=> tw.stop_p ##0 tw.bus_idle;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle bus");  // [RULE15]

    property p_ack_phase;
        @(posedge ref_clk) disable iff (rst)
        !sda_oe_n |-> ph_r == TW_ACK && tw.addr_hit;
    endproperty
    a_ack_phase: assert property (p_ack_phase) else $error("data driven outside ack");  // [RULE16]

    property p_idle_level;
        @(posedge ref_clk) disable iff (rst)
        tw.bus_idle |-> $past(scl_s2) && $past(sda_s2);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle with a line low");  // [RULE13]
endmodule : sss_twi_cond
`default_nettype wire

//--- src/sss_ctrl.sv
// operating state control: hard standby, soft standby, streaming
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
// Functional notes
// [RULE1] exactly one of three operating states
// [RULE2] stream off finishes row or frame first
// [RULE3] soft standby keeps settings, stops output
// [RULE4] init trigger starts initialisation from soft standby
// [RULE5] initialisation lasts 2400 reference clocks, returns
// [RULE6] shutdown low gives hard standby, defaults
// [RULE7] stay hard standby while shutdown low
// [RULE8] host stops streaming before asserting shutdown
// [RULE9] host stops reference clock 100 us earlier
// [RULE10] host removes supplies in order, 200 us
// [RULE11] host raises I/O supply first
// [RULE12] bus slave only, clock never driven
// [RULE13] bus idle when both lines high
// [RULE14] start is data falling, clock high
// [RULE15] stop is data rising, clock high
// [RULE16] transaction framing: start, address, ack, bytes, stop
// [RULE17] shutdown stops output, restores defaults at once
// [RULE18] trigger self-clears; stream bit starts streaming
// [RULE19] writes during initialisation deferred, kept in order
module sss_ctrl
    import sss_pkg::*;
#(
    parameter int INIT_REFCLKS = `SSS_INIT_REFCLKS  // init length
) (
    input  wire logic       ref_clk,        // 40 MHz block clock
    input  wire logic       rst,            // sync reset, high
    input  wire logic       hard_standby_n, // shutdown pin, low
    input  wire logic       ref_clock_in,   // reference clock pin
    input  wire logic       scl_in,         // bus clock pin
    input  wire logic       sda_in,         // bus data pin
    output var  logic       sda_out,        // bus data level
    output var  logic       sda_oe_n,       // bus data enable, low
    input  wire logic       stream_wr,      // stream bit write pulse
    input  wire logic       stream_val,     // value written
    input  wire logic       init_wr,        // init trigger write
    input  wire logic       frame_mode,     // stop at frame end
    input  wire logic       row_end,        // row boundary pulse
    input  wire logic       frame_end,      // frame boundary pulse
    output var  logic [1:0] sys_state,      // operating state
    output var  logic       pix_out_en,     // pixel output running
    output var  logic       stream_en,      // stream bit readback
    output var  logic       init_busy,      // initialisation running
    output var  logic       bus_idle        // bus idle flag
);
    localparam int CW = `SSS_INIT_CNT_W;
    localparam logic [CW-1:0] INIT_LAST = CW'(INIT_REFCLKS - 1);

    sss_twi_if tw ();

    sss_state_e    state_r;
    logic          hs_s1, hs_s2;
    logic          rc_s1, rc_s2, rc_d;
    logic          rc_rise, dev_rst, boundary, init_done;
    logic          stream_r, init_r;
    logic [CW-1:0] cnt_r;
    logic          pend_str_r, pend_val_r, pend_init_r, init_first_r;
    logic          apply_str, apply_init, apply_val;

    // bus front end; held in reset with the rest of the device
    sss_twi_cond u_twi (
        .ref_clk  (ref_clk),
        .rst      (dev_rst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe_n (sda_oe_n),
        .tw       (tw.cond)
    );

    // pins from outside pass two flops before use
    always_ff @(posedge ref_clk) begin
        hs_s1 <= hard_standby_n;
        hs_s2 <= hs_s1;
        rc_s1 <= ref_clock_in;
        rc_s2 <= rc_s1;
        rc_d  <= rc_s2;
    end

    // shutdown acts as a reset of all device state
    assign dev_rst = rst | ~hs_s2;  // [RULE17] [RULE6]
    assign rc_rise = rc_s2 & ~rc_d;

    // row or frame end, as configured
    assign boundary = frame_mode ? frame_end : row_end;  // [RULE2]

    // last reference edge of initialisation
    assign init_done = init_r & rc_rise & (cnt_r == INIT_LAST);  // [RULE5]

    // pick which deferred or direct write takes effect this cycle
    always_comb begin
        apply_str  = 1'b0;
        apply_init = 1'b0;
        apply_val  = stream_val;
        if (init_r) begin
            apply_str  = 1'b0;  // [RULE19] held while busy
            apply_init = 1'b0;
        end else if (pend_init_r && (init_first_r || !pend_str_r)) begin
            apply_init = 1'b1;  // [RULE19] older write first
        end else if (pend_str_r) begin
            apply_str = 1'b1;
            apply_val = pend_val_r;
        end else begin
            apply_str  = stream_wr;
            apply_init = init_wr;
        end
    end

    // deferred writes; a write landing in the completion cycle waits too
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            pend_str_r   <= 1'b0;
            pend_val_r   <= 1'b0;
            pend_init_r  <= 1'b0;
            init_first_r <= 1'b0;
        end else begin
            if (apply_str && !init_r)
                pend_str_r <= 1'b0;
            if (apply_init && !init_r)
                pend_init_r <= 1'b0;
            if (stream_wr && (init_r || pend_str_r || pend_init_r)) begin
                pend_str_r <= 1'b1;  // [RULE19] newest value wins
                pend_val_r <= stream_val;
                if (!pend_init_r)
                    init_first_r <= 1'b0;
            end
            if (init_wr && (init_r || pend_str_r || pend_init_r)) begin
                pend_init_r <= 1'b1;  // [RULE19]
                if (!pend_str_r && !pend_init_r)
                    init_first_r <= 1'b1;
            end
        end
    end

    // stream-enable bit; kept through soft standby
    always_ff @(posedge ref_clk) begin
        if (dev_rst)
            stream_r <= 1'b0;  // [RULE6] default
        else if (apply_str)
            stream_r <= apply_val;  // [RULE3] only writes change it
    end

    // initialisation trigger, accepted only in soft standby
    always_ff @(posedge ref_clk) begin
        if (dev_rst)
            init_r <= 1'b0;
        else if (init_done)
            init_r <= 1'b0;  // [RULE18] self-clearing
        else if (apply_init && state_r == SSS_SOFT)
            init_r <= 1'b1;  // [RULE4]
    end

    // count reference clock edges; the pin clock may stop, so no timeout
    always_ff @(posedge ref_clk) begin
        if (dev_rst || !init_r)
            cnt_r <= '0;
        else if (rc_rise)
            cnt_r <= cnt_r + CW'(1);  // [RULE5]
    end

    // operating state machine
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            state_r <= SSS_HARD;  // [RULE7] held while pin low
        end else begin
            case (state_r)
                SSS_HARD:
                    state_r <= SSS_SOFT;  // [RULE1] reset released
                SSS_SOFT: begin
                    if (stream_r && !init_r)
                        state_r <= SSS_STREAM;  // [RULE18]
                end
                SSS_STREAM: begin
                    if (!stream_r && boundary)
                        state_r <= SSS_SOFT;  // [RULE2]
                end
                default:
                    state_r <= SSS_HARD;
            endcase
        end
    end

    // outputs, each from a flop; output stops at once on shutdown
    always_ff @(posedge ref_clk) begin
        if (dev_rst) begin
            pix_out_en <= 1'b0;  // [RULE17]
            sys_state  <= 2'h0;
            stream_en  <= 1'b0;
            init_busy  <= 1'b0;
            bus_idle   <= 1'b0;
        end else begin
            pix_out_en <= (state_r == SSS_STREAM);  // [RULE3]
            sys_state  <= state_r;
            stream_en  <= stream_r;
            init_busy  <= init_r;
            bus_idle   <= tw.bus_idle;
        end
    end

    // helper: reference edges seen since initialisation began
    logic [CW-1:0] chk_cnt;
    always_ff @(posedge ref_clk) begin
        if (dev_rst || (!init_r))
            chk_cnt <= '0;
        else if (rc_rise)
            chk_cnt <= chk_cnt + CW'(1);
    end

    sequence s_init_end;
        init_r ##1 !init_r;
    endsequence

    property p_one_state;
        @(posedge ref_clk) disable iff (rst)
        state_r inside {SSS_HARD, SSS_SOFT, SSS_STREAM};
    endproperty
    a_one_state: assert property (p_one_state) else $error("illegal state");  // [RULE1]

    property p_boundary_stop;
        @(posedge ref_clk) disable iff (dev_rst)
        state_r == SSS_STREAM && !stream_r && boundary |=> state_r == SSS_SOFT ##1 !pix_out_en;
    endproperty
    a_boundary_stop: assert property (p_boundary_stop) else $error("no stop at boundary");  // [RULE2]

    property p_no_early_stop;
        @(posedge ref_clk) disable iff (dev_rst)
        state_r == SSS_STREAM && !boundary |=> state_r == SSS_STREAM;
    endproperty
    a_no_early_stop: assert property (p_no_early_stop) else $error("left stream mid row");  // [RULE2]

    property p_soft_quiet;
        @(posedge ref_clk) disable iff (dev_rst)
        state_r == SSS_SOFT |=> !pix_out_en && ($stable(stream_r) || $past(apply_str));
    endproperty
    a_soft_quiet: assert property (p_soft_quiet) else $error("soft standby not quiet");  // [RULE3]

    property p_init_soft_only;
        @(posedge ref_clk) disable iff (dev_rst)
        $rose(init_r) |-> $past(state_r) == SSS_SOFT;
    endproperty
    a_init_soft_only: assert property (p_init_soft_only) else $error("init outside soft");  // [RULE4]

    property p_init_len;
        @(posedge ref_clk) disable iff (dev_rst)
        s_init_end |-> $past(chk_cnt) == INIT_LAST && state_r == SSS_SOFT;
    endproperty
    a_init_len: assert property (p_init_len) else $error("init length wrong");  // [RULE5]

    property p_hard_hold;
        @(posedge ref_clk) disable iff (rst)
        !hs_s2 |=> state_r == SSS_HARD && !pix_out_en && !stream_en;
    endproperty
    a_hard_hold: assert property (p_hard_hold) else $error("not in hard standby");  // [RULE7]

    property p_stream_go;
        @(posedge ref_clk) disable iff (dev_rst)
        state_r == SSS_SOFT && stream_r && !init_r |=> state_r == SSS_STREAM ##1 pix_out_en;
    endproperty
    a_stream_go: assert property (p_stream_go) else $error("stream bit ignored");  // [RULE18]

    property p_defer;
        @(posedge ref_clk) disable iff (dev_rst)
        init_r && stream_wr |=> $stable(stream_r) && pend_str_r;
    endproperty
    a_defer: assert property (p_defer) else $error("write applied during init");  // [RULE19]
endmodule : sss_ctrl
`default_nettype wire

//--- test/sss_host_model.sv
// host controller model: reference clock, shutdown pin and bus master
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
module sss_host_model (
    input  wire logic ref_clk,        // block clock, paces the bus
    input  wire logic sda_bus,        // resolved data line
    output var  logic ref_clock_in,   // reference clock to the device
    output var  logic hard_standby_n, // shutdown pin, low = standby
    output var  logic scl_line,       // bus clock, master only
    output var  logic sda_pull_low    // high while pulling data low
);
    localparam int HALF = 8; // bus phase in block clocks, above the 4 needed
    logic ref_run, io_supply, analog_supply;
    // 200 ns reference clock, parked low while stopped
    initial begin
        ref_run = 1'b1;
        io_supply = 1'b1;
        analog_supply = 1'b1;
        hard_standby_n = 1'b1;
        scl_line = 1'b1;
        sda_pull_low = 1'b0;
        ref_clock_in = 1'b0;
        #31;
        forever begin
            #100;
            ref_clock_in = ref_run ? ~ref_clock_in : 1'b0;
        end
    end
    task automatic phase();
        repeat (HALF) @(posedge ref_clk);
    endtask : phase
    // data falls with clock high; also used as repeated start
    task automatic bus_start();
        sda_pull_low <= 1'b0;
        phase();
        scl_line <= 1'b1;
        phase();
        sda_pull_low <= 1'b1;
        phase();
        scl_line <= 1'b0;
        phase();
    endtask : bus_start
    // data rises with clock high, bus released
    task automatic bus_stop();
        sda_pull_low <= 1'b1;
        phase();
        scl_line <= 1'b1;
        phase();
        sda_pull_low <= 1'b0;
        phase();
    endtask : bus_stop
    // one byte MSB first, then the acknowledge slot is sampled
    task automatic bus_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull_low <= ~b[i];
            phase();
            scl_line <= 1'b1;
            phase();
            scl_line <= 1'b0;
            phase();
        end
        sda_pull_low <= 1'b0;
        phase();
        scl_line <= 1'b1;
        repeat (HALF / 2) @(posedge ref_clk);
        ack = ~sda_bus;
        repeat (HALF / 2) @(posedge ref_clk);
        scl_line <= 1'b0;
        phase();
    endtask : bus_byte
    // orderly power-down stops the clock well before the pin falls
    task automatic shutdown(input logic orderly);
        if (orderly) begin
            ref_run = 1'b0;
            repeat (`SSS_T_CLKOFF_CYC) @(posedge ref_clk);
        end
        hard_standby_n <= 1'b0;
        if (orderly) begin
            repeat (`SSS_T_SUPPLY_CYC) @(posedge ref_clk);
            analog_supply = 1'b0; // analog domains first, pin supply last
            io_supply = 1'b0;
        end
    endtask : shutdown
    // pin released and clock restarted; supplies tracked as levels only
    task automatic power_up();
        io_supply = 1'b1; // the pin's own supply comes first
        @(posedge ref_clk);
        analog_supply = 1'b1;
        hard_standby_n <= 1'b1;
        ref_run = 1'b1;
    endtask : power_up
endmodule : sss_host_model
`default_nettype wire

//--- test/sss_ctrl_tb_top.sv
// self-checking bench for the operating state control block
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
module sss_ctrl_tb_top;
    localparam int INIT_N = 20; // short initialisation for the run
    logic       ref_clk, rst, hard_standby_n, ref_clock_in, scl_line, sda_bus, sda_pull_low;
    logic       sda_out, sda_oe_n, stream_wr, stream_val, init_wr, frame_mode, row_end, frame_end;
    logic [1:0] sys_state;
    logic       pix_out_en, stream_en, init_busy, bus_idle, ack;
    int         bad_count = 0;
    int         checks_done = 0;
    // open-drain data line with pull-up
    assign sda_bus = (sda_pull_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
    sss_host_model u_host (.ref_clk(ref_clk), .sda_bus(sda_bus), .ref_clock_in(ref_clock_in),
        .hard_standby_n(hard_standby_n), .scl_line(scl_line), .sda_pull_low(sda_pull_low));
    sss_ctrl #(.INIT_REFCLKS(INIT_N)) u_dut (.ref_clk(ref_clk), .rst(rst), .hard_standby_n(hard_standby_n),
        .ref_clock_in(ref_clock_in), .scl_in(scl_line), .sda_in(sda_bus), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .stream_wr(stream_wr), .stream_val(stream_val), .init_wr(init_wr),
        .frame_mode(frame_mode), .row_end(row_end), .frame_end(frame_end), .sys_state(sys_state),
        .pix_out_en(pix_out_en), .stream_en(stream_en), .init_busy(init_busy), .bus_idle(bus_idle));
    // 40 MHz block clock
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic wr_stream(input logic v);
        @(posedge ref_clk);
        stream_wr <= 1'b1;
        stream_val <= v;
        @(posedge ref_clk);
        stream_wr <= 1'b0;
    endtask : wr_stream
    // one-cycle pulse on init, row end (0) or frame end (1)
    task automatic pulse(input int which);
        @(posedge ref_clk);
        if (which == 2) init_wr <= 1'b1;
        else if (which == 1) frame_end <= 1'b1;
        else row_end <= 1'b1;
        @(posedge ref_clk);
        init_wr <= 1'b0;
        frame_end <= 1'b0;
        row_end <= 1'b0;
    endtask : pulse
    task automatic wait_state(input logic [1:0] s);
        for (int n = 0; n < 12 && sys_state !== s; n++) @(posedge ref_clk);
    endtask : wait_state
    task automatic t_reset();
        cyc(4);
        chk("state", {6'h00, sys_state}, 8'h01);
        chk("stream_en", {7'h00, stream_en}, 8'h00);
        chk("busy", {7'h00, init_busy}, 8'h00);
        for (int n = 0; n < 10 && bus_idle !== 1'b1; n++) @(posedge ref_clk);
        chk("bus_idle", {7'h00, bus_idle}, 8'h01);
    endtask : t_reset
    // row mode then frame mode: stop waits for the configured boundary
    task automatic t_stream();
        for (int m = 0; m < 2; m++) begin
            frame_mode <= m[0];
            wr_stream(1'b1);
            wait_state(2'h2);
            cyc(2);
            chk("state", {6'h00, sys_state}, 8'h02);
            chk("pix", {7'h00, pix_out_en}, 8'h01);
            pulse(2);
            cyc(4);
            chk("busy", {7'h00, init_busy}, 8'h00);
            wr_stream(1'b0);
            cyc(4);
            chk("state", {6'h00, sys_state}, 8'h02);
            if (m == 1) begin
                pulse(0);
                cyc(3);
                chk("state", {6'h00, sys_state}, 8'h02);
            end
            pulse(m);
            cyc(3);
            chk("state", {6'h00, sys_state}, 8'h01);
            chk("pix", {7'h00, pix_out_en}, 8'h00);
        end
    endtask : t_stream
    // initialisation counted in reference clocks, stream write deferred
    task automatic t_init();
        frame_mode <= 1'b0;
        pulse(2);
        for (int n = 0; n < 4 && init_busy !== 1'b1; n++) @(posedge ref_clk);
        chk("busy", {7'h00, init_busy}, 8'h01);
        wr_stream(1'b1);
        cyc(3);
        chk("stream_en", {7'h00, stream_en}, 8'h00);
        repeat (INIT_N - 3) @(posedge ref_clock_in);
        @(posedge ref_clk);
        chk("busy", {7'h00, init_busy}, 8'h01);
        chk("state", {6'h00, sys_state}, 8'h01);
        for (int n = 0; n < 60 && init_busy !== 1'b0; n++) @(posedge ref_clk);
        chk("busy", {7'h00, init_busy}, 8'h00);
        wait_state(2'h2);
        chk("state", {6'h00, sys_state}, 8'h02);
        wr_stream(1'b0);
        pulse(0);
        wait_state(2'h1);
        chk("state", {6'h00, sys_state}, 8'h01);
    endtask : t_init
    // matching address acked, restart to another address not acked
    task automatic t_bus();
        u_host.bus_start();
        chk("bus_idle", {7'h00, bus_idle}, 8'h00);
        u_host.bus_byte({`SSS_TWI_ADDR, 1'b0}, ack);
        chk("addr ack", {7'h00, ack}, 8'h01);
        u_host.bus_byte(8'h3A, ack);
        chk("data ack", {7'h00, ack}, 8'h01);
        u_host.bus_byte(8'hC5, ack);
        chk("odd data ack", {7'h00, ack}, 8'h01);
        u_host.bus_byte(8'h5C, ack);
        chk("next data ack", {7'h00, ack}, 8'h01);
        u_host.bus_start();
        u_host.bus_byte({`SSS_TWI_ADDR, 1'b1}, ack);
        chk("read addr ack", {7'h00, ack}, 8'h01);
        u_host.bus_byte(8'hFF, ack);
        chk("read released", {7'h00, ack}, 8'h00);
        u_host.bus_start();
        u_host.bus_byte({`SSS_TWI_ADDR ^ 7'h01, 1'b0}, ack);
        chk("miss ack", {7'h00, ack}, 8'h00);
        u_host.bus_stop();
        for (int n = 0; n < 10 && bus_idle !== 1'b1; n++) @(posedge ref_clk);
        chk("bus_idle", {7'h00, bus_idle}, 8'h01);
    endtask : t_bus
    // abrupt shutdown while streaming, then an orderly one from soft standby
    task automatic t_hard();
        wr_stream(1'b1);
        wait_state(2'h2);
        u_host.shutdown(1'b0);
        cyc(4);
        chk("pix", {7'h00, pix_out_en}, 8'h00);
        chk("state", {6'h00, sys_state}, 8'h00);
        cyc(40);
        chk("state", {6'h00, sys_state}, 8'h00);
        u_host.power_up();
        wait_state(2'h1);
        chk("state", {6'h00, sys_state}, 8'h01);
        chk("stream_en", {7'h00, stream_en}, 8'h00);
        u_host.shutdown(1'b1);
        cyc(4);
        chk("state", {6'h00, sys_state}, 8'h00);
        u_host.power_up();
        wait_state(2'h1);
        chk("state", {6'h00, sys_state}, 8'h01);
    endtask : t_hard
    task automatic final_report();
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        rst = 1'b1;
        stream_wr = 1'b0;
        stream_val = 1'b0;
        init_wr = 1'b0;
        frame_mode = 1'b0;
        row_end = 1'b0;
        frame_end = 1'b0;
        cyc(6);
        rst <= 1'b0;
        t_reset();
        t_stream();
        t_init();
        t_bus();
        t_hard();
        final_report();
    end
    // watchdog well beyond the expected run of about 14k cycles
    initial begin
        #1_000_000;
        bad_count++;
        final_report();
    end
endmodule : sss_ctrl_tb_top
`default_nettype wire
